//--- tcr_pkg.sv
package tcr_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CONST_W = 9;

    localparam logic [7:0] ADDR_MULT = 8'hC2;
    localparam logic [7:0] ADDR_DIV = 8'hC3;
    localparam logic [7:0] ADDR_OFFS = 8'hC4;
    localparam logic [7:0] ADDR_PRIOR = 8'hC5;
    localparam logic [7:0] ADDR_STAT = 8'hC6;

    localparam logic [7:0] RST_MULT = 8'h00;
    localparam logic [7:0] RST_DIV = 8'h00;
    localparam logic [7:0] RST_OFFS = 8'h00;
    localparam logic [7:0] RST_PRIOR = 8'h00;

    localparam logic [7:0] FIELD_MAX = 8'hFF;
    localparam int unsigned STAT_MULT_OVF = 0;
    localparam int unsigned STAT_DIV_OVF = 1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tcr_req_t;

    typedef struct packed {
        logic [CONST_W-1:0] mult;
        logic [CONST_W-1:0] div;
        logic [DATA_W-1:0] offs;
        logic mult_ovf;
        logic div_ovf;
    } tcr_const_t;

endpackage : tcr_pkg

//--- tcr_plus_one.sv
`timescale 1ns/1ps
module tcr_plus_one (
    input wire logic [7:0] field_i,
    output logic [8:0] value_o,
    output logic ovf_o
);

    // Nine bits keep 256 visible; ovf_o flags what an 8-bit path would lose
    assign value_o = {1'b0, field_i} + 9'h001;
    assign ovf_o = (field_i == tcr_pkg::FIELD_MAX);

endmodule : tcr_plus_one

//--- tcr_regs.sv
`timescale 1ns/1ps
// Operation
// - Multiplier, divider, offset: 8-bit read/write at 0xC2, 0xC3, 0xC4.
// - Effective multiplier is field plus one, 1 to 256.
// - Effective divider is field plus one, 1 to 256.
// - Offset constant is the field itself, 0 to 255.
// - Field 255 plus one overflows eight bits; flagged, not a valid constant.
module tcr_regs (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire tcr_pkg::tcr_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output tcr_pkg::tcr_const_t const_o
);

    // Entry order follows the address map; status is computed, not stored
    localparam int unsigned NUM_REGS = 4;
    localparam int unsigned IDX_W = 2;
    localparam logic [IDX_W-1:0] IDX_MULT = 2'h0;
    localparam logic [IDX_W-1:0] IDX_DIV = 2'h1;
    localparam logic [IDX_W-1:0] IDX_OFFS = 2'h2;
    // Spare prior entry: stored and read back, feeds nothing
    localparam logic [IDX_W-1:0] IDX_PRIOR = 2'h3;

    logic [7:0] bank [NUM_REGS];
    logic bank_hit;
    logic stat_hit;
    logic [IDX_W-1:0] bank_idx;
    logic bank_wr;
    logic [7:0] status;
    logic [7:0] rd_mux;
    logic [8:0] next_mult;
    logic [8:0] next_div;
    logic mult_ovf;
    logic div_ovf;

    // Address decode shared by reads and writes
    always_comb
    begin
        bank_hit = 1'b0;
        stat_hit = 1'b0;
        bank_idx = IDX_MULT;
        case (req_i.addr)
            tcr_pkg::ADDR_MULT:
            begin
                bank_hit = 1'b1;
                bank_idx = IDX_MULT;
            end
            tcr_pkg::ADDR_DIV:
            begin
                bank_hit = 1'b1;
                bank_idx = IDX_DIV;
            end
            tcr_pkg::ADDR_OFFS:
            begin
                bank_hit = 1'b1;
                bank_idx = IDX_OFFS;
            end
            tcr_pkg::ADDR_PRIOR:
            begin
                bank_hit = 1'b1;
                bank_idx = IDX_PRIOR;
            end
            tcr_pkg::ADDR_STAT:
            begin
                stat_hit = 1'b1;
            end
            default:
            begin
                bank_hit = 1'b0;
                stat_hit = 1'b0;
            end
        endcase
    end

    // Writes to status or unmapped addresses vanish; no error raised
    assign bank_wr = req_i.wr && bank_hit;

    // One flip-flop byte per entry; only nrst_i clears them
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g = g + 1)
        begin : g_entry
            localparam logic [7:0] RST_VAL =
                (IDX_W'(g) == IDX_MULT) ? tcr_pkg::RST_MULT :
                (IDX_W'(g) == IDX_DIV) ? tcr_pkg::RST_DIV :
                (IDX_W'(g) == IDX_OFFS) ? tcr_pkg::RST_OFFS :
                tcr_pkg::RST_PRIOR;

            always_ff @(posedge clock_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    bank[g] <= RST_VAL;
                end
                else if (bank_wr && (bank_idx == IDX_W'(g)))
                begin
                    bank[g] <= req_i.wdata;
                end
            end
        end
    endgenerate

    // Field plus one, in nine bits so 256 stays visible
    tcr_plus_one u_mult (
        .field_i(bank[IDX_MULT]),
        .value_o(next_mult),
        .ovf_o(mult_ovf)
    );

    tcr_plus_one u_div (
        .field_i(bank[IDX_DIV]),
        .value_o(next_div),
        .ovf_o(div_ovf)
    );

    // Overflow flags gathered at their status bit positions
    always_comb
    begin
        status = 8'h00;
        status[tcr_pkg::STAT_MULT_OVF] = mult_ovf;
        status[tcr_pkg::STAT_DIV_OVF] = div_ovf;
    end

    // Unmapped addresses read zero rather than a stale byte
    // A read and a write in one cycle return the old byte
    always_comb
    begin
        rd_mux = 8'h00;
        if (bank_hit)
        begin
            rd_mux = bank[bank_idx];
        end
        else if (stat_hit)
        begin
            rd_mux = status;
        end
    end

    // Valid pulse: one cycle per taken read
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= req_i.rd;
        end
    end

    // Data held at zero between reads so a late sample cannot pass
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (req_i.rd)
        begin
            rdata_o <= rd_mux;
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

    // Constants registered so the outputs come from flip-flops
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            const_o.mult <= 9'h000;
        end
        else
        begin
            const_o.mult <= next_mult;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            const_o.div <= 9'h000;
        end
        else
        begin
            const_o.div <= next_div;
        end
    end

    // Offset passes through with no increment
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            const_o.offs <= 8'h00;
        end
        else
        begin
            const_o.offs <= bank[IDX_OFFS];
        end
    end

    // Overflow kept visible rather than clamped; host must avoid it
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            const_o.mult_ovf <= 1'b0;
            const_o.div_ovf <= 1'b0;
        end
        else
        begin
            const_o.mult_ovf <= mult_ovf;
            const_o.div_ovf <= div_ovf;
        end
    end

endmodule : tcr_regs

//--- tcr_regs_properties.sv
`timescale 1ns/1ps
module tcr_regs_properties (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire tcr_pkg::tcr_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire tcr_pkg::tcr_const_t const_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    a_read_pulse: assert property (rvalid_o == $past(req_i.rd))
        else $error("rvalid off");
    a_mult_plus: assert property (req_i.wr && req_i.addr == 8'hC2 |=>
        ##1 const_o.mult == {1'b0, $past(req_i.wdata, 2)} + 9'h001)
        else $error("mult off");
    a_div_plus: assert property (req_i.wr && req_i.addr == 8'hC3 |=>
        ##1 const_o.div == {1'b0, $past(req_i.wdata, 2)} + 9'h001)
        else $error("div off");
    a_offs_direct: assert property (req_i.wr && req_i.addr == 8'hC4
        |=> ##1 const_o.offs == $past(req_i.wdata, 2))
        else $error("offs off");
    a_ovf_flag: assert property (const_o.div_ovf == const_o.div[8])
        else $error("ovf off");
    a_mult_ovf: assert property (
        const_o.mult_ovf == const_o.mult[8])
        else $error("mult ovf off");
    a_idle_zero: assert property (!rvalid_o |-> rdata_o == 8'h00)
        else $error("rdata not idle");
    a_hold_value: assert property (!req_i.wr [*2] |=> $stable(const_o))
        else $error("const moved");
endmodule : tcr_regs_properties
bind tcr_regs tcr_regs_properties tcr_regs_properties_i (.clock_i(clock_i),
    .nrst_i(nrst_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .const_o(const_o));

//--- tcr_host.sv
`timescale 1ns/1ps
module tcr_host (
    input wire logic clock_i,
    output tcr_pkg::tcr_req_t req_o
);
    initial req_o = '0;
    // One-cycle strobe; 0xFF only when a test asks for it
    task automatic access(input logic w, input logic [7:0] a, d);
        @(negedge clock_i);
        req_o = {w, !w, a, d};
        @(negedge clock_i);
        req_o = '0;
    endtask : access
endmodule : tcr_host

//--- tcr_regs_tb_top.sv
`timescale 1ns/1ps
module tcr_regs_tb_top;
    logic clock_i = 1'h0;
    logic nrst_i = 1'h0;
    tcr_pkg::tcr_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    tcr_pkg::tcr_const_t cst;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #20 clock_i = ~clock_i;
    tcr_host tcr_host_i (.clock_i(clock_i), .req_o(req));
    tcr_regs tcr_regs_i (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .const_o(cst));
    task automatic chk(input string n, input logic [8:0] e, g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Valid bit rides on top of the read byte
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        tcr_host_i.access(1'h0, a, 8'h00);
        chk("read", e, {rvalid, rdata});
    endtask : rd
    task automatic t_defaults;
        for (int a = 8'hC2; a < 8'hC8; a++) rd(a[7:0], 9'h100);
        chk("mult", 9'h001, cst.mult);
        chk("div", 9'h001, cst.div);
        chk("offs", 9'h000, {1'b0, cst.offs});
        chk("ovf", 9'h000, {7'h00, cst.div_ovf, cst.mult_ovf});
        @(negedge clock_i);
        chk("idle", 9'h000, {rvalid, rdata});
        $display("t_defaults done");
    endtask : t_defaults
    task automatic t_values;
        tcr_host_i.access(1'h1, 8'hC2, 8'h05);
        tcr_host_i.access(1'h1, 8'hC3, 8'hFF);
        tcr_host_i.access(1'h1, 8'hC4, 8'hFF);
        @(negedge clock_i);
        chk("mult", 9'h006, cst.mult);
        chk("div", 9'h100, cst.div);
        chk("offs", 9'h0FF, {1'b0, cst.offs});
        chk("ovf", 9'h002, {7'h00, cst.div_ovf, cst.mult_ovf});
        rd(8'hC3, 9'h1FF);
        rd(8'hC6, 9'h102);
        rd(8'hC2, 9'h105);
        nrst_i = 1'h0;
        @(negedge clock_i);
        nrst_i = 1'h1;
        rd(8'hC4, 9'h100);
        rd(8'hC6, 9'h100);
        chk("mult", 9'h001, cst.mult);
        chk("div", 9'h001, cst.div);
        $display("t_values done");
    endtask : t_values
    // Writes to status and unmapped addresses must leave the bank alone
    task automatic t_limits;
        tcr_host_i.access(1'h1, 8'hC2, 8'hFF);
        tcr_host_i.access(1'h1, 8'hC6, 8'h00);
        tcr_host_i.access(1'h1, 8'hC5, 8'h5A);
        tcr_host_i.access(1'h1, 8'hC7, 8'h33);
        chk("mult", 9'h100, cst.mult);
        chk("ovf", 9'h001, {7'h00, cst.div_ovf, cst.mult_ovf});
        rd(8'hC6, 9'h101);
        rd(8'hC5, 9'h15A);
        rd(8'hC7, 9'h100);
        rd(8'hC3, 9'h100);
        rd(8'hC4, 9'h100);
        $display("t_limits done");
    endtask : t_limits
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    always @(posedge clock_i)
        if (++cycles == 500)
        begin
            fail_count++;
            give_verdict();
        end
    initial
    begin
        repeat (5) @(negedge clock_i);
        nrst_i = 1'h1;
        t_defaults();
        t_values();
        t_limits();
        give_verdict();
    end
endmodule : tcr_regs_tb_top
